// File: rtl/csp_shared_params.sv
// shared sequencer variables with the sequencer state machine they steer
module csp_shared_params (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        var_addr,
    input  wire logic              var_wr,
    input  wire logic [7:0]        var_wdata,
    input  wire logic              var_rd,
    output      logic [7:0]        var_rdata,
    input  wire logic              frame_start,
    input  wire logic              flash_on,
    input  wire logic              ae_fast,
    input  wire logic              awb_fast,
    input  wire logic              outdoor_enable,
    input  wire logic [7:0]        exposure_value,
    input  wire logic [7:0]        analog_virtual_gain,
    input  wire logic [7:0]        digital_gain_first,
    input  wire logic [7:0]        digital_gain_second,
    output      logic [7:0]        seq_state_code,
    output      logic              driver_timeout,
    output      logic              refresh_pulse,
    output      logic              refresh_mode_pulse,
    output      csp_pkg::csp_drive_t drive
);
    import csp_pkg::*;

    csp_state_t st;
    csp_state_t next_st;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] seq_code(input csp_seq_t s);
        case (s)
            CSP_INIT:      seq_code = 8'h00;
            CSP_MC_PREV:   seq_code = 8'h01;
            CSP_ENT_PREV:  seq_code = 8'h02;
            CSP_PREVIEW:   seq_code = 8'h03;
            CSP_LEAVE_PRV: seq_code = 8'h04;
            CSP_MC_CAP:    seq_code = 8'h05;
            CSP_ENT_CAP:   seq_code = 8'h06;
            CSP_CAPTURE:   seq_code = 8'h07;
            CSP_LEAVE_CAP: seq_code = 8'h08;
            CSP_STANDBY:   seq_code = 8'h09;
            default:       seq_code = 8'h00;
        endcase
    endfunction : seq_code

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a >= OFS_COMMAND && a <= OFS_WB_FAST_S) || a == OFS_TIMEOUT
              || (a >= OFS_DAYLIGHT && a <= OFS_STILL_CNT);
    endfunction : mapped

    // bright value below the gain window, dark value above it, midpoint inside
    function automatic logic [7:0] ll_pick(input logic [7:0] bright, input logic [7:0] dark,
                                           input logic [1:0] zone, input logic en);
        logic [8:0] sum;
        sum = {1'b0, bright} + {1'b0, dark};
        if (!en || zone == 2'h0) begin
            ll_pick = bright;
        end else if (zone == 2'h2) begin
            ll_pick = dark;
        end else begin
            ll_pick = sum[8:1];
        end
    endfunction : ll_pick

    logic [9:0] virt_gain;
    logic [1:0] ll_zone;
    logic       advance;
    logic       stable;
    logic       host_cmd;

    always_comb begin
        virt_gain = {3'h0, analog_virtual_gain[7:1]} + {6'h00, digital_gain_first[7:4]}
                  + {4'h0, digital_gain_second[7:2]};
        if (virt_gain >= {2'h0, st.vars[OFS_LL_GMAX]}) begin
            ll_zone = 2'h2;
        end else if (virt_gain > {2'h0, st.vars[OFS_LL_GMIN]}) begin
            ll_zone = 2'h1;
        end else begin
            ll_zone = 2'h0;
        end
    end

    assign advance  = st.vars[OFS_STEP][STEP_ON_BIT] ? st.vars[OFS_STEP][STEP_NEXT_BIT]
                                                     : frame_start;
    assign stable   = st.seq == CSP_PREVIEW || st.seq == CSP_STANDBY
                   || (st.seq == CSP_CAPTURE && st.vars[OFS_CAPTURE][CAP_VIDEO_BIT]);
    assign host_cmd = var_wr && var_addr == OFS_COMMAND && var_wdata != 8'h00;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st              = st;
        next_st.refresh      = 1'b0;
        next_st.refresh_mode = 1'b0;
        next_st.timeout      = 1'b0;

        // consumed step request clears; a host write below wins
        if (st.vars[OFS_STEP][STEP_ON_BIT] && advance) begin
            next_st.vars[OFS_STEP][STEP_NEXT_BIT] = 1'b0;
        end

        if (st.prog != PROG_NONE) begin
            case (st.prog)
                PROG_PREVIEW: begin
                    if (st.seq == CSP_CAPTURE) begin
                        next_st.seq = CSP_LEAVE_CAP;
                    end else if (st.seq == CSP_STANDBY || st.seq == CSP_INIT) begin
                        next_st.seq = CSP_MC_PREV;
                    end
                end
                PROG_CAPTURE: begin
                    if (st.seq == CSP_PREVIEW) begin
                        next_st.seq = CSP_LEAVE_PRV;
                    end
                end
                PROG_STANDBY:    next_st.seq = CSP_STANDBY;
                PROG_LOCK:       next_st.vars[OFS_FLASH][FLASH_LOCK_BIT] = flash_on;
                PROG_REFRESH:    next_st.refresh = 1'b1;
                PROG_REFRESH_MD: next_st.refresh_mode = 1'b1;
                default:         next_st.prog = PROG_NONE;
            endcase
            next_st.prog = PROG_NONE;
        end else if (advance) begin
            case (st.seq)
                CSP_INIT:      next_st.seq = CSP_MC_PREV;
                CSP_MC_PREV:   next_st.seq = CSP_ENT_PREV;
                CSP_ENT_PREV:  next_st.seq = CSP_PREVIEW;
                CSP_LEAVE_PRV: next_st.seq = CSP_MC_CAP;
                CSP_MC_CAP:    next_st.seq = CSP_ENT_CAP;
                CSP_ENT_CAP:   next_st.seq = CSP_CAPTURE;
                CSP_CAPTURE: begin
                    if (!st.vars[OFS_CAPTURE][CAP_VIDEO_BIT]) begin
                        next_st.still_cnt = st.still_cnt + 8'h01;
                        if (st.still_cnt + 8'h01 >= st.vars[OFS_STILL_CNT]) begin
                            next_st.seq = CSP_LEAVE_CAP;
                        end
                    end
                end
                CSP_LEAVE_CAP: next_st.seq = CSP_MC_PREV;
                default:       next_st.seq = st.seq;
            endcase
        end
        if (next_st.seq != st.seq) begin
            next_st.still_cnt = 8'h00;
        end

        // frames since the last state change, counted only outside the stable states, drive the timeout
        if (next_st.seq != st.seq || stable) begin
            next_st.frame_cnt = 8'h00;
        end else if (frame_start) begin
            next_st.frame_cnt = st.frame_cnt + 8'h01;
            if (st.frame_cnt + 8'h01 == st.vars[OFS_TIMEOUT]) begin
                next_st.timeout = 1'b1;
            end
        end

        // host access
        if (var_wr && mapped(var_addr) && var_addr != OFS_STATE) begin
            if (var_addr == OFS_COMMAND) begin
                if (host_cmd) begin
                    next_st.prog = var_wdata[2:0];
                end
            end else begin
                next_st.vars[var_addr] = var_wdata;
            end
        end
        // lock status wins over a host write of the flash byte in the same cycle
        if (st.prog == PROG_LOCK) begin
            next_st.vars[OFS_FLASH][FLASH_LOCK_BIT] = flash_on;
        end
        if (var_rd) begin
            if (var_addr == OFS_STATE) begin
                next_st.rdata = seq_code(st.seq);
            end else if (mapped(var_addr)) begin
                next_st.rdata = st.vars[var_addr];
            end else begin
                next_st.rdata = 8'h00;
            end
        end
        next_st.vars[OFS_COMMAND] = 8'h00;
        next_st.vars[OFS_STATE]   = 8'h00;

        // driver outputs
        next_st.drive.ae_weight  = ae_fast ? st.vars[OFS_AE_FAST_W] : st.vars[OFS_AE_CONT_W];
        next_st.drive.ae_steps   = ae_fast ? st.vars[OFS_AE_FAST_S] : st.vars[OFS_AE_CONT_S];
        next_st.drive.awb_weight = awb_fast ? st.vars[OFS_WB_FAST_W] : st.vars[OFS_WB_CONT_W];
        next_st.drive.awb_steps  = awb_fast ? st.vars[OFS_WB_FAST_S] : st.vars[OFS_WB_CONT_S];
        next_st.drive.daylight   = outdoor_enable
                                && exposure_value > st.vars[OFS_DAYLIGHT];
        next_st.drive.saturation = ll_pick(st.vars[OFS_SAT_MAX], st.vars[OFS_SAT_MIN], ll_zone,
                                           st.vars[OFS_LL_OPT][LL_SAT_BIT]);
        next_st.drive.interp_thr = ll_pick(st.vars[OFS_INTERP_MIN], st.vars[OFS_INTERP_MAX],
                                           ll_zone, st.vars[OFS_LL_OPT][LL_INTERP_BIT]);
        next_st.drive.aperture_corr = ll_pick(st.vars[OFS_APC_MAX], st.vars[OFS_APC_MIN],
                                              ll_zone, st.vars[OFS_LL_OPT][LL_APC_BIT]);
        next_st.drive.aperture_thr = ll_pick(st.vars[OFS_APT_MIN], st.vars[OFS_APT_MAX],
                                             ll_zone, st.vars[OFS_LL_OPT][LL_APT_BIT]);
        next_st.drive.luma_filter = st.vars[OFS_LL_OPT][LL_YFILT_BIT] && ll_zone != 2'h0;
        next_st.drive.flash_led   = st.vars[OFS_FLASH][1:0] == FLASH_LED;
        next_st.drive.flash_xenon = st.vars[OFS_FLASH][1:0] == FLASH_XENON;
        next_st.drive.flash_burst = st.vars[OFS_FLASH][1:0] == FLASH_BURST;
        next_st.drive.video     = st.vars[OFS_CAPTURE][CAP_VIDEO_BIT];
        next_st.drive.video_ae  = next_st.drive.video && st.vars[OFS_CAPTURE][CAP_AE_BIT];
        next_st.drive.video_awb = next_st.drive.video && st.vars[OFS_CAPTURE][CAP_AWB_BIT];
        next_st.drive.video_hg  = next_st.drive.video && st.vars[OFS_CAPTURE][CAP_HG_BIT];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= CSP_RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign var_rdata          = st.rdata;
    assign seq_state_code     = seq_code(st.seq);
    assign driver_timeout     = st.timeout;
    assign refresh_pulse      = st.refresh;
    assign refresh_mode_pulse = st.refresh_mode;
    assign drive              = st.drive;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // a second command in the pending cycle legally queues behind the first
    sequence s_cmd_written;
        host_cmd && var_wdata[2:0] != PROG_NONE && st.prog == PROG_NONE ##1 !host_cmd;
    endsequence
    sequence s_cmd_runs;
        st.prog != PROG_NONE ##1 st.prog == PROG_NONE;
    endsequence

    chk_cmd_self_clear: assert property (s_cmd_written |-> s_cmd_runs)
        else $error("command program not run and cleared");
    chk_state_code_map: assert property (st.seq == CSP_PREVIEW |-> seq_state_code == 8'h03)
        else $error("preview state code wrong");
    chk_step_hold: assert property (st.vars[OFS_STEP][STEP_ON_BIT]
            && !st.vars[OFS_STEP][STEP_NEXT_BIT] && st.prog == PROG_NONE |=> $stable(st.seq))
        else $error("sequencer moved in step mode without a step");
    chk_step_consume: assert property (st.vars[OFS_STEP][STEP_ON_BIT]
            && st.vars[OFS_STEP][STEP_NEXT_BIT] && !var_wr |=> !st.vars[OFS_STEP][STEP_NEXT_BIT])
        else $error("step request not consumed");
    chk_lock_flash: assert property (st.prog == PROG_LOCK && flash_on
            |=> st.vars[OFS_FLASH][FLASH_LOCK_BIT])
        else $error("flash lock bit not set");
    chk_flash_decode: assert property (st.vars[OFS_FLASH][1:0] == FLASH_BURST
            && $stable(st.vars[OFS_FLASH]) |=> drive.flash_burst && !drive.flash_led)
        else $error("flash kind decode wrong");
    chk_ae_select: assert property (ae_fast |=> drive.ae_steps == $past(st.vars[OFS_AE_FAST_S]))
        else $error("fast exposure steps not selected");
    chk_daylight_pick: assert property (outdoor_enable
            && exposure_value > st.vars[OFS_DAYLIGHT] |=> drive.daylight)
        else $error("daylight correction not forced");
    chk_video_gate: assert property (!st.vars[OFS_CAPTURE][CAP_VIDEO_BIT]
            |=> !drive.video_ae && !drive.video_awb && !drive.video_hg)
        else $error("video-only enable active in still mode");
    chk_timeout_pulse: assert property (driver_timeout |=> !driver_timeout)
        else $error("timeout not a single pulse");
    chk_still_leave: assert property (st.seq == CSP_CAPTURE && st.prog == PROG_NONE
            && advance && !st.vars[OFS_CAPTURE][CAP_VIDEO_BIT]
            && st.still_cnt + 8'h01 >= st.vars[OFS_STILL_CNT] |=> st.seq == CSP_LEAVE_CAP)
        else $error("still capture did not end after frame count");
    chk_var_hold: assert property (!var_wr |=> $stable(st.vars[OFS_SAT_MAX]))
        else $error("variable changed without a write");

endmodule : csp_shared_params

// File: rtl/csp_pkg.sv
// constants, types and reset image of the camera sequencer shared variables
// Summary of operation
// - state variable reports sequencer state byte code
// - positive command clears, runs program, resumes state
// - step bit 0 selects step-by-step sequencing
// - writing step bit 1 advances one step
// - flash code 1 LED, 2 xenon, 3 burst
// - flash bit 7 set when flash on at lock
// - continuous exposure weight defaults 8, 32 none
// - continuous exposure step count defaults 2
// - fast exposure weight 32, steps 1
// - continuous balance weight 8, steps 2
// - fast balance weight 32, steps 1
// - drivers time out after frame count, 30
// - EV above threshold plus option forces daylight
// - low-light option bits 0..4 enable adjustments
// - low-light range between virtual gain min, max
// - saturation ranges max 128 to min 0
// - interpolation threshold ranges 16 to 64
// - aperture correction 2..0, threshold 8..64
// - capture bit 1 video; bits 4-6 video only
// - still capture takes programmed frame count, 3
package csp_pkg;

    // ----------------------------------------------------------------
    // variable offsets
    // ----------------------------------------------------------------
    localparam int unsigned CSP_VAR_COUNT  = 34;
    localparam logic [7:0] OFS_COMMAND     = 8'h03;
    localparam logic [7:0] OFS_STATE       = 8'h04;
    localparam logic [7:0] OFS_STEP        = 8'h05;
    localparam logic [7:0] OFS_FLASH       = 8'h06;
    localparam logic [7:0] OFS_AE_CONT_W   = 8'h07;
    localparam logic [7:0] OFS_AE_CONT_S   = 8'h08;
    localparam logic [7:0] OFS_AE_FAST_W   = 8'h09;
    localparam logic [7:0] OFS_AE_FAST_S   = 8'h0A;
    localparam logic [7:0] OFS_WB_CONT_W   = 8'h0B;
    localparam logic [7:0] OFS_WB_CONT_S   = 8'h0C;
    localparam logic [7:0] OFS_WB_FAST_W   = 8'h0D;
    localparam logic [7:0] OFS_WB_FAST_S   = 8'h0E;
    localparam logic [7:0] OFS_TIMEOUT     = 8'h12;
    localparam logic [7:0] OFS_DAYLIGHT    = 8'h14;
    localparam logic [7:0] OFS_LL_OPT      = 8'h15;
    localparam logic [7:0] OFS_LL_GMIN     = 8'h16;
    localparam logic [7:0] OFS_LL_GMAX     = 8'h17;
    localparam logic [7:0] OFS_SAT_MAX     = 8'h18;
    localparam logic [7:0] OFS_SAT_MIN     = 8'h19;
    localparam logic [7:0] OFS_INTERP_MIN  = 8'h1A;
    localparam logic [7:0] OFS_INTERP_MAX  = 8'h1B;
    localparam logic [7:0] OFS_APC_MAX     = 8'h1C;
    localparam logic [7:0] OFS_APC_MIN     = 8'h1D;
    localparam logic [7:0] OFS_APT_MIN     = 8'h1E;
    localparam logic [7:0] OFS_APT_MAX     = 8'h1F;
    localparam logic [7:0] OFS_CAPTURE     = 8'h20;
    localparam logic [7:0] OFS_STILL_CNT   = 8'h21;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned STEP_ON_BIT    = 0;
    localparam int unsigned STEP_NEXT_BIT  = 1;
    localparam int unsigned FLASH_LOCK_BIT = 7;
    localparam int unsigned CAP_VIDEO_BIT  = 1;
    localparam int unsigned CAP_AE_BIT     = 4;
    localparam int unsigned CAP_AWB_BIT    = 5;
    localparam int unsigned CAP_HG_BIT     = 6;
    localparam int unsigned LL_INTERP_BIT  = 0;
    localparam int unsigned LL_SAT_BIT     = 1;
    localparam int unsigned LL_APC_BIT     = 2;
    localparam int unsigned LL_APT_BIT     = 3;
    localparam int unsigned LL_YFILT_BIT   = 4;

    // ----------------------------------------------------------------
    // codes
    // ----------------------------------------------------------------
    localparam logic [1:0] FLASH_LED       = 2'h1;
    localparam logic [1:0] FLASH_XENON     = 2'h2;
    localparam logic [1:0] FLASH_BURST     = 2'h3;
    localparam logic [2:0] PROG_NONE       = 3'h0;
    localparam logic [2:0] PROG_PREVIEW    = 3'h1;
    localparam logic [2:0] PROG_CAPTURE    = 3'h2;
    localparam logic [2:0] PROG_STANDBY    = 3'h3;
    localparam logic [2:0] PROG_LOCK       = 3'h4;
    localparam logic [2:0] PROG_REFRESH    = 3'h5;
    localparam logic [2:0] PROG_REFRESH_MD = 3'h6;

    typedef enum logic [3:0] {
        CSP_INIT      = 4'h0,
        CSP_MC_PREV   = 4'h1,
        CSP_ENT_PREV  = 4'h3,
        CSP_PREVIEW   = 4'h2,
        CSP_LEAVE_PRV = 4'h6,
        CSP_MC_CAP    = 4'h7,
        CSP_ENT_CAP   = 4'h5,
        CSP_CAPTURE   = 4'h4,
        CSP_LEAVE_CAP = 4'hC,
        CSP_STANDBY   = 4'hD
    } csp_seq_t;

    typedef logic [CSP_VAR_COUNT-1:0][7:0] csp_vars_t;

    typedef struct packed {
        logic [7:0] ae_weight;
        logic [7:0] ae_steps;
        logic [7:0] awb_weight;
        logic [7:0] awb_steps;
        logic [7:0] saturation;
        logic [7:0] interp_thr;
        logic [7:0] aperture_corr;
        logic [7:0] aperture_thr;
        logic       luma_filter;
        logic       daylight;
        logic       flash_led;
        logic       flash_xenon;
        logic       flash_burst;
        logic       video;
        logic       video_ae;
        logic       video_awb;
        logic       video_hg;
    } csp_drive_t;

    typedef struct packed {
        csp_vars_t  vars;
        csp_seq_t   seq;
        logic [2:0] prog;
        logic [7:0] frame_cnt;
        logic [7:0] still_cnt;
        logic [7:0] rdata;
        logic       timeout;
        logic       refresh;
        logic       refresh_mode;
        csp_drive_t drive;
    } csp_state_t;

    function automatic logic [7:0] csp_reset_value(input int unsigned ofs);
        case (ofs)
            7, 11:        csp_reset_value = 8'h08;
            8, 12:        csp_reset_value = 8'h02;
            9, 13:        csp_reset_value = 8'h20;
            10, 14:       csp_reset_value = 8'h01;
            18:           csp_reset_value = 8'h1E;
            20:           csp_reset_value = 8'h0A;
            21:           csp_reset_value = 8'h60;
            22:           csp_reset_value = 8'h51;
            23:           csp_reset_value = 8'h5A;
            24:           csp_reset_value = 8'h80;
            26:           csp_reset_value = 8'h10;
            27, 31:       csp_reset_value = 8'h40;
            28:           csp_reset_value = 8'h02;
            30:           csp_reset_value = 8'h08;
            33:           csp_reset_value = 8'h03;
            default:      csp_reset_value = 8'h00;
        endcase
    endfunction : csp_reset_value

    function automatic csp_state_t csp_reset_state();
        csp_state_t s;
        s = '0;
        for (int unsigned i = 0; i < CSP_VAR_COUNT; i++) begin
            s.vars[i] = csp_reset_value(i);
        end
        s.seq = CSP_INIT;
        return s;
    endfunction : csp_reset_state

    localparam csp_state_t CSP_RESET_STATE = csp_reset_state();

endpackage : csp_pkg

// File: dv/csp_host_model.sv
// host model that moves one byte at a time over the variable port
module csp_host_model (
    input  wire logic       ref_clk,
    output      logic [7:0] var_addr,
    output      logic       var_wr,
    output      logic [7:0] var_wdata,
    output      logic       var_rd,
    input  wire logic [7:0] var_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        var_addr  = 8'h00;
        var_wr    = 1'b0;
        var_wdata = 8'h00;
        var_rd    = 1'b0;
    end
    // ----
    // transfers; idle lines show the inverse of the last value
    // ----
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        var_addr  <= a;
        var_wdata <= d;
        var_wr    <= 1'b1;
        @(posedge ref_clk);
        var_wr    <= 1'b0;
        var_addr  <= ~a;
        var_wdata <= ~d;
    endtask : put
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        var_addr <= a;
        var_rd   <= 1'b1;
        @(posedge ref_clk);
        var_rd   <= 1'b0;
        var_addr <= ~a;
        #1;
        d = var_rdata;
    endtask : get
endmodule : csp_host_model

// File: dv/csp_shared_params_tb_top.sv
// self-checking bench for the shared sequencer variables
module csp_shared_params_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csp_pkg::*;
    // ----
    // signals and reference model
    // ----
    logic       ref_clk, rst_n = 1'b0, frame_start = 1'b0, flash_on = 1'b0;
    logic       ae_fast = 1'b0, awb_fast = 1'b0, outdoor_enable = 1'b0;
    logic [2:0] seen = 3'h0;
    logic [7:0] exposure_value = 8'h00, gain_a = 8'h00, gain_d1 = 8'h00, gain_d2 = 8'h00;
    logic [7:0] var_addr, var_wdata, var_rdata, seq_state_code, got, wv;
    logic       var_wr, var_rd, driver_timeout, refresh_pulse, refresh_mode_pulse;
    csp_drive_t drive;
    int         errors = 0, total_checks = 0;
    logic [7:0] mdl [0:33];
    localparam logic [7:0] DEFS [5:33] = '{8'h00, 8'h00, 8'h08, 8'h02, 8'h20, 8'h01, 8'h08,
        8'h02, 8'h20, 8'h01, 8'h00, 8'h00, 8'h00, 8'h1E, 8'h00, 8'h0A, 8'h60, 8'h51, 8'h5A,
        8'h80, 8'h00, 8'h10, 8'h40, 8'h02, 8'h00, 8'h08, 8'h40, 8'h00, 8'h03};
    csp_shared_params u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .var_addr(var_addr),
        .var_wr(var_wr), .var_wdata(var_wdata), .var_rd(var_rd), .var_rdata(var_rdata),
        .frame_start(frame_start), .flash_on(flash_on), .ae_fast(ae_fast), .awb_fast(awb_fast),
        .outdoor_enable(outdoor_enable), .exposure_value(exposure_value),
        .analog_virtual_gain(gain_a), .digital_gain_first(gain_d1),
        .digital_gain_second(gain_d2), .seq_state_code(seq_state_code),
        .driver_timeout(driver_timeout), .refresh_pulse(refresh_pulse),
        .refresh_mode_pulse(refresh_mode_pulse), .drive(drive));
    csp_host_model u_host (.ref_clk(ref_clk), .var_addr(var_addr), .var_wr(var_wr),
        .var_wdata(var_wdata), .var_rd(var_rd), .var_rdata(var_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // sticky record of the one-cycle pulses: refresh mode, timeout, refresh
    always @(posedge ref_clk) begin
        seen <= seen | {refresh_mode_pulse === 1'b1, driver_timeout === 1'b1,
                        refresh_pulse === 1'b1};
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_host.get(a, got);
        chk($sformatf("variable %h", a), exp, got);
    endtask : rd_chk
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic pulse_frame();
        @(posedge ref_clk) frame_start <= 1'b1;
        @(posedge ref_clk) frame_start <= 1'b0;
    endtask : pulse_frame
    task automatic complete_run();
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    initial begin
        #200000;
        errors++;
        complete_run();
    end
    // ----
    // scenarios
    // ----
    initial begin
        void'($urandom(33));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 5; a <= 33; a++) rd_chk(8'(a), DEFS[a]);
        rd_chk(OFS_STATE, 8'h00);
        chk("bright end", 8'h80, drive.saturation);
        chk("interp low", 8'h10, drive.interp_thr);
        @(posedge ref_clk) gain_a <= 8'hFF;
        settle(3);
        chk("opt off", 8'h08, drive.aperture_thr);
        u_host.put(OFS_LL_OPT, 8'h1F);
        settle(2);
        chk("dark end", 8'h40, drive.aperture_thr);
        chk("dark corr", 8'h00, drive.aperture_corr);
        chk("dark sat", 8'h00, drive.saturation);
        chk("interp high", 8'h40, drive.interp_thr);
        chk("luma filter", 8'h01, 8'(drive.luma_filter));
        @(posedge ref_clk) outdoor_enable <= 1'b1;
        exposure_value <= 8'h0B;
        settle(3);
        chk("daylight", 8'h01, 8'(drive.daylight));
        @(posedge ref_clk) exposure_value <= 8'h0A;
        settle(3);
        chk("no daylight", 8'h00, 8'(drive.daylight));
        u_host.put(OFS_TIMEOUT, 8'h02);
        u_host.put(OFS_STEP, 8'h01);
        pulse_frame();
        pulse_frame();
        rd_chk(OFS_STATE, 8'h00);
        chk("timeout", 8'h01, 8'(seen[1]));
        u_host.put(OFS_STEP, 8'h03);
        rd_chk(OFS_STEP, 8'h01);
        rd_chk(OFS_STATE, 8'h01);
        u_host.put(OFS_STEP, 8'h00);
        pulse_frame();
        u_host.put(OFS_STATE, 8'h09);
        rd_chk(OFS_STATE, 8'h02);
        for (int k = 1; k <= 3; k++) begin
            u_host.put(OFS_FLASH, 8'(k));
            settle(1);
            chk("flash kind", 8'(1 << (k - 1)),
                {5'h00, drive.flash_burst, drive.flash_xenon, drive.flash_led});
        end
        flash_on <= 1'b1;
        u_host.put(OFS_COMMAND, 8'h04);
        settle(3);
        rd_chk(OFS_FLASH, 8'h83);
        u_host.put(OFS_COMMAND, 8'h05);
        rd_chk(OFS_COMMAND, 8'h00);
        settle(3);
        chk("refresh", 8'h01, 8'(seen[0]));
        chk("state kept", 8'h02, seq_state_code);
        u_host.put(OFS_COMMAND, 8'h06);
        settle(2);
        chk("refresh mode", 8'h01, 8'(seen[2]));
        pulse_frame();
        u_host.put(OFS_COMMAND, 8'h02);
        repeat (4) pulse_frame();
        settle(1);
        chk("capture", 8'h07, seq_state_code);
        repeat (2) pulse_frame();
        settle(1);
        chk("still end", 8'h08, seq_state_code);
        u_host.put(OFS_COMMAND, 8'h03);
        settle(2);
        chk("standby", 8'h09, seq_state_code);
        u_host.put(OFS_COMMAND, 8'h01);
        settle(2);
        chk("to preview", 8'h01, seq_state_code);
        @(posedge ref_clk) gain_a <= 8'h00;
        ae_fast <= 1'($urandom);
        awb_fast <= 1'($urandom);
        for (int a = 7; a <= 33; a++) begin
            wv = 8'($urandom);
            mdl[a] = (a inside {[15:17], 19}) ? 8'h00 : wv;
            u_host.put(8'(a), wv);
        end
        for (int a = 7; a <= 33; a++) rd_chk(8'(a), mdl[a]);
        chk("ae weight", ae_fast ? mdl[9] : mdl[7], drive.ae_weight);
        chk("awb steps", awb_fast ? mdl[14] : mdl[12], drive.awb_steps);
        chk("saturation", (mdl[23] == 8'h00 && mdl[21][1]) ? mdl[25] : mdl[24],
            drive.saturation);
        chk("video", mdl[32][1] ? {5'h00, mdl[32][6:4]} : 8'h00,
            {5'h00, drive.video_hg, drive.video_awb, drive.video_ae});
        complete_run();
    end
endmodule : csp_shared_params_tb_top
